// ### srs_ext_rst_model.sv
// Purpose: Model of the external reset circuit that drives the reset pin.
// Assumes: Push-pull driver, so the pin is always at a driven level.
// Notes:   The bench asks for a hold; the pin moves only at falling edges.
`default_nettype none

module srs_ext_rst_model (
    input wire logic clk_sys_i,
    input wire logic hold_i,
    output var logic ext_rst_n_o
);
    // ------------------------------------------------------------------
    // Pin driver
    // ------------------------------------------------------------------
    initial ext_rst_n_o = 1'b1;
    // Low while held, released high once the hold ends
    always @(negedge clk_sys_i) begin
        ext_rst_n_o <= ~hold_i;
    end
endmodule

`default_nettype wire

// ### srs_params.svh
// Purpose: Constants of the system reset sequencer: timing, cause codes.
// Assumes: 50 MHz system clock.
// Notes:   Definitions only.
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SRS_CLK_PERIOD_NS 20
// Oscillator warm-up time, least value, rounded up to whole cycles
`define SRS_WARM_UP_NS 100000
`define SRS_WARM_CYCLES \
    ((`SRS_WARM_UP_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_WARM_BITS 16
`define SRS_WDT_BITS 12

// ----------------------------------------------------------------------
// Reset cause codes, {cause_flag_hi, cause_flag_lo}
// ----------------------------------------------------------------------
`define SRS_CAUSE_WDT 2'h0
`define SRS_CAUSE_RSVD 2'h1
`define SRS_CAUSE_POR_LVD 2'h2
`define SRS_CAUSE_EXT 2'h3

`endif

// ### srs_pkg.sv
// Purpose: Types shared by the system reset sequencer files.
// Assumes: Nothing beyond the constants header.
// Notes:   Sequence states follow the order of the reset steps.
`default_nettype none

package srs_pkg;
    typedef enum logic [1:0] {
        ST_CHECK,
        ST_INIT,
        ST_WARM,
        ST_RUN
    } srs_state_type;

    typedef logic [1:0] srs_cause_type;
endpackage

`default_nettype wire

// ### srs_seq.sv
// Purpose: System reset sequencer: orders every reset through check,
//          register init, oscillator warm-up, then run from address 0.
// Assumes: All inputs but arst_n_i synchronous to clk_sys_i; the pin is still synced.
// Notes:   Power-on is the asynchronous reset itself.
//
// Notes on behaviour
// - Watchdog overflow forces a full system reset
// - Watchdog counts to overflow unless firmware clears
// - After watchdog reset, resume normal mode
// - Steps: check, init registers, warm-up, run
// - Stay in reset while supply unusable
// - Low-voltage trip starts the common reset sequence
// - Reset pin counts only when option enables
// - Reset pin is active low
// - Pin high and nothing else: run normally
// - Pin honoured at power-up and while running
// - Pin low at power-up holds reset
// - Two flags record the reset cause
// - Any reset stops execution, clears program counter
`include "srs_params.svh"
`default_nettype none

module srs_seq #(
    parameter int WARM_CYCLES = `SRS_WARM_CYCLES,
    parameter int WARM_BITS = `SRS_WARM_BITS,
    parameter int WDT_BITS = `SRS_WDT_BITS
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire logic supply_ok_i,
    input wire logic lvd_trip_i,
    input wire logic ext_rst_en_i,
    input wire logic ext_rst_n_i,
    input wire logic wdt_clear_i,
    output var logic sys_rst_n_o,
    output var logic cpu_run_o,
    output var logic pc_clear_o,
    output var logic cause_flag_hi_o,
    output var logic cause_flag_lo_o
);
    import srs_pkg::*;

    localparam logic [WARM_BITS-1:0] WARM_LOAD =
        WARM_BITS'(WARM_CYCLES - 1);

    srs_state_type state_q, state_d;
    srs_cause_type cause_q, cause_d;
    logic [WARM_BITS-1:0] warm_cnt_q;
    logic pin_meta_q, pin_sync_q;
    logic [1:0] pin_fill_q;
    logic ext_hit, rst_hit;

    srs_wdt_if wdt_bus ();

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    // Counts only while code executes; a firmware clear is a plain input
    assign wdt_bus.run = cpu_run_o;
    assign wdt_bus.clear = wdt_clear_i;

    srs_wdt #(
        .WDT_BITS(WDT_BITS)
    ) u_wdt (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i),
        .wdt(wdt_bus.cnt)
    );

    // ------------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------------
    // Resets low, so the pin must be seen high before release
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else if (clk_en_i) begin
            pin_meta_q <= ext_rst_n_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Marks the synchroniser as holding a real pin sample; until then its
    // low reset value must not be recorded as an external reset cause
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_fill_q <= 2'h0;
        end else if (clk_en_i) begin
            pin_fill_q <= {pin_fill_q[0], 1'b1};
        end
    end

    // Pin counts only when the option selects it; low level asserts
    assign ext_hit = ext_rst_en_i && !pin_sync_q;
    // Watchdog only matters while running
    assign rst_hit = lvd_trip_i || ext_hit ||
                     (state_q == ST_RUN && wdt_bus.ovf);

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    // Any source returns to the check step, from whatever step
    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        if (rst_hit) begin
            state_d = ST_CHECK;
            // Low voltage outranks the pin, the pin outranks the watchdog;
            // a pin still filling its synchroniser records nothing, so a
            // clean power-up keeps the power-on code
            if (lvd_trip_i) begin
                cause_d = `SRS_CAUSE_POR_LVD;
            end else if (ext_hit && pin_fill_q[1]) begin
                cause_d = `SRS_CAUSE_EXT;
            end else if (state_q == ST_RUN && wdt_bus.ovf) begin
                cause_d = `SRS_CAUSE_WDT;
            end
        end else begin
            unique case (state_q)
                // Wait out a dead supply and a held pin here
                ST_CHECK: begin
                    if (supply_ok_i) begin
                        state_d = ST_INIT;
                    end
                end
                ST_INIT: state_d = ST_WARM;
                ST_WARM: begin
                    if (warm_cnt_q == '0) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: state_d = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_CHECK;
        end else if (clk_en_i) begin
            state_q <= state_d;
        end
    end

    // Warm-up counter is loaded during init, so warm-up is exact
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            warm_cnt_q <= WARM_LOAD;
        end else if (clk_en_i) begin
            if (state_q == ST_INIT) begin
                warm_cnt_q <= WARM_LOAD;
            end else if (state_q == ST_WARM && warm_cnt_q != '0) begin
                warm_cnt_q <= warm_cnt_q - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------------
    // Power-on reads as the low-voltage code
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cause_q <= `SRS_CAUSE_POR_LVD;
        end else if (clk_en_i) begin
            cause_q <= cause_d;
        end
    end

    assign cause_flag_hi_o = cause_q[1];
    assign cause_flag_lo_o = cause_q[0];

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Registered from the next state so they line up with state_q.
    // System reset low through check and init also clears any low-power
    // mode, so every restart comes up in normal mode.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sys_rst_n_o <= 1'b0;
            cpu_run_o <= 1'b0;
            pc_clear_o <= 1'b1;
        end else if (clk_en_i) begin
            sys_rst_n_o <= !(state_d == ST_CHECK || state_d == ST_INIT);
            cpu_run_o <= (state_d == ST_RUN);
            pc_clear_o <= (state_d != ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_enter_init;
        clk_en_i && state_q == ST_CHECK && state_d == ST_INIT;
    endsequence

    sequence s_init_body;
        state_q == ST_INIT && !sys_rst_n_o && !cpu_run_o;
    endsequence

    a_ovf_stops_run: assert property (
        (clk_en_i && state_q == ST_RUN && wdt_bus.ovf)
        |=> !cpu_run_o && !sys_rst_n_o && cause_q == `SRS_CAUSE_WDT)
        else $error("watchdog overflow did not reset the system");

    a_init_step_order: assert property (
        s_enter_init |=> s_init_body)
        else $error("register init step not taken after check");

    a_warm_to_run: assert property (
        (clk_en_i && !rst_hit && state_q == ST_WARM && warm_cnt_q == '0)
        |=> cpu_run_o && !pc_clear_o && sys_rst_n_o)
        else $error("warm-up end did not start execution");

    a_deadband_hold: assert property (
        (clk_en_i && state_q == ST_CHECK && !supply_ok_i)
        |=> state_q == ST_CHECK && !sys_rst_n_o)
        else $error("left reset with supply unusable");

    a_lvd_resets: assert property (
        (clk_en_i && lvd_trip_i)
        |=> !cpu_run_o && cause_q == `SRS_CAUSE_POR_LVD)
        else $error("low-voltage trip did not reset");

    a_pin_ignored: assert property (
        (clk_en_i && state_q == ST_RUN && !ext_rst_en_i && !lvd_trip_i
         && !wdt_bus.ovf) |=> cpu_run_o)
        else $error("disabled reset pin disturbed execution");

    a_pin_low_resets: assert property (
        (clk_en_i && ext_rst_en_i && !ext_rst_n_i) ##1 clk_en_i ##1
        clk_en_i |=> state_q == ST_CHECK && pc_clear_o)
        else $error("low reset pin did not hold reset");

    a_ext_cause: assert property (
        (clk_en_i && ext_hit && pin_fill_q[1] && !lvd_trip_i)
        |=> {cause_flag_hi_o, cause_flag_lo_o} == `SRS_CAUSE_EXT)
        else $error("external reset cause not recorded");

    a_fill_no_cause: assert property (
        (clk_en_i && ext_hit && !pin_fill_q[1] && !lvd_trip_i)
        |=> cause_q == $past(cause_q))
        else $error("unfilled pin synchroniser recorded a cause");

    a_pc_clear_tie: assert property (
        pc_clear_o == !cpu_run_o && (sys_rst_n_o || pc_clear_o))
        else $error("program counter not held clear in reset");

    a_warm_length: assert property (
        (clk_en_i && state_q == ST_INIT && !rst_hit)
        |=> warm_cnt_q == WARM_LOAD && !cpu_run_o)
        else $error("warm-up counter not loaded with full count");
endmodule

`default_nettype wire

// ### srs_wdt.sv
// Purpose: Watchdog counter that pulses on overflow.
// Assumes: Firmware clear arrives as a synchronous pulse.
// Notes:   Counter rests at zero while the core is not executing.
`include "srs_params.svh"
`default_nettype none

module srs_wdt #(
    parameter int WDT_BITS = `SRS_WDT_BITS
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    srs_wdt_if.cnt wdt
);
    import srs_pkg::*;

    localparam logic [WDT_BITS-1:0] CNT_MAX = '1;

    logic [WDT_BITS-1:0] cnt_q;
    logic ovf_q;

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    // Counts on until overflow unless cleared; a clear restarts
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= '0;
        end else if (clk_en_i) begin
            if (!wdt.run || wdt.clear) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // Overflow pulse; wraps so a stuck core keeps being caught
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovf_q <= 1'b0;
        end else if (clk_en_i) begin
            ovf_q <= wdt.run && !wdt.clear && (cnt_q == CNT_MAX);
        end
    end

    assign wdt.ovf = ovf_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_wdt_clear_restart: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (clk_en_i && wdt.clear) |=> (cnt_q == '0) && !ovf_q)
        else $error("watchdog clear did not restart the count");

    a_wdt_keeps_count: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (clk_en_i && wdt.run && !wdt.clear)
        |=> (cnt_q == $past(cnt_q) + 1'b1))
        else $error("watchdog stopped counting while running");
endmodule

`default_nettype wire

// ### srs_wdt_if.sv
// Purpose: Carrier between the sequencer and its watchdog counter.
// Assumes: Same clock on both sides.
// Notes:   run enables counting, clear restarts, ovf is a one-cycle pulse.
`default_nettype none

interface srs_wdt_if;
    logic run;
    logic clear;
    logic ovf;

    modport ctrl (output run, output clear, input ovf);
    modport cnt (input run, input clear, output ovf);
endinterface

`default_nettype wire

// ### test_system_reset_sequencer.sv
// Purpose: Self-checking bench of the reset sequencer top.
// Assumes: Short warm-up and watchdog counts set by parameters.
// Notes:   Inputs change at falling edges, outputs sampled there too.
`include "srs_params.svh"
`default_nettype none

module test_system_reset_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    import srs_pkg::*;
    localparam int WARM = 4;
    localparam int WDT = 4;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic supply_ok = 1'b1;
    logic low_voltage_detector = 1'b0;
    logic ext_en = 1'b1;
    logic hold = 1'b0;
    logic wdt_clr = 1'b0;
    logic pin_n;
    logic sys_rst_n, cpu_run, pc_clear, flag_hi, flag_lo;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] lfsr = 16'h691D;
    int n;

    // ------------------------------------------------------------------
    // Clock, timeout and instances
    // ------------------------------------------------------------------
    always #10 clk = ~clk;
    // Whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            summarize();
        end
    end

    srs_seq #(.WARM_CYCLES(WARM), .WDT_BITS(WDT)) dut (
        .clk_sys_i(clk), .arst_n_i(arst_n), .clk_en_i(clk_en),
        .supply_ok_i(supply_ok), .lvd_trip_i(low_voltage_detector), .ext_rst_en_i(ext_en),
        .ext_rst_n_i(pin_n), .wdt_clear_i(wdt_clr),
        .sys_rst_n_o(sys_rst_n), .cpu_run_o(cpu_run),
        .pc_clear_o(pc_clear), .cause_flag_hi_o(flag_hi),
        .cause_flag_lo_o(flag_lo)
    );

    srs_ext_rst_model ext (
        .clk_sys_i(clk), .hold_i(hold), .ext_rst_n_o(pin_n)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Galois LFSR, seed 26909
    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return v[0] ? ((v >> 1) ^ 16'hB400) : (v >> 1);
    endfunction

    // Cause code for simultaneous sources, LOW_VOLTAGE_DETECTOR first, then the pin
    function automatic srs_cause_type cause_of(input logic l, input logic p);
        if (l) return `SRS_CAUSE_POR_LVD;
        if (p) return `SRS_CAUSE_EXT;
        return `SRS_CAUSE_WDT;
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Wait for the core run flag to reach a level, counting edges
    task automatic wait_run(input logic lvl, input int max, output int k);
        k = 0;
        while (cpu_run !== lvl && k < max) begin
            @(negedge clk);
            k++;
        end
        check("run wait", {1'b0, cpu_run}, {1'b0, lvl});
    endtask

    // Run with random watchdog clears closer than overflow; a drop is
    // caught by sampling every cycle
    task automatic run_cleared(input int len);
        logic drop;
        drop = 1'b0;
        repeat (len) begin
            @(negedge clk);
            lfsr = next_rand(lfsr);
            wdt_clr = (lfsr[2:0] == 3'h0) || (n % 8 == 7);
            n++;
            if (cpu_run !== 1'b1) drop = 1'b1;
        end
        // Let the last clear stand for its cycle before dropping it
        @(negedge clk);
        wdt_clr = 1'b0;
        check("run held", {1'b0, drop}, 2'h0);
    endtask

    task automatic summarize();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons,
                 bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        n = 0;
        repeat (5) @(negedge clk);
        check("por flags", {flag_hi, flag_lo}, cause_of(1, 0));
        check("por outs", {sys_rst_n, pc_clear}, 2'h1);
        arst_n = 1'b1;
        // Registers released first, then warm-up counted to run
        while (sys_rst_n !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
            check("init order", {1'b0, cpu_run}, 2'h0);
        end
        wait_run(1'b1, 20, n);
        check("warm len", 16'(n), 16'(WARM));
        check("por kept", {flag_hi, flag_lo}, cause_of(1, 0));
        check("pc free", {1'b0, pc_clear}, 2'h0);
        $display("Test power-on done");

        // Watchdog: cleared run holds, then silence overflows
        run_cleared(60);
        wait_run(1'b0, (1 << WDT) + 4, n);
        check("wdt flags", {flag_hi, flag_lo}, cause_of(0, 0));
        check("wdt pc", {sys_rst_n, pc_clear}, 2'h1);
        wait_run(1'b1, WARM + 10, n);
        $display("Test watchdog done");

        // Low-voltage trip, then dead-band supply keeps reset
        low_voltage_detector = 1'b1;
        supply_ok = 1'b0;
        @(negedge clk);
        @(negedge clk);
        check("lvd stop", {1'b0, cpu_run}, 2'h0);
        check("lvd flags", {flag_hi, flag_lo}, cause_of(1, 1));
        low_voltage_detector = 1'b0;
        lfsr = next_rand(lfsr);
        repeat (20 + lfsr[3:0]) @(negedge clk);
        check("deadband", {sys_rst_n, cpu_run}, 2'h0);
        supply_ok = 1'b1;
        wait_run(1'b1, WARM + 10, n);
        $display("Test low voltage done");

        // Pin pulled low while running, held, then released
        hold = 1'b1;
        wait_run(1'b0, 6, n);
        check("pin flags", {flag_hi, flag_lo}, cause_of(0, 1));
        repeat (30) @(negedge clk);
        check("pin hold", {sys_rst_n, cpu_run}, 2'h0);
        hold = 1'b0;
        wait_run(1'b1, WARM + 12, n);
        $display("Test pin reset done");

        // Pin ignored when the option does not select reset
        ext_en = 1'b0;
        hold = 1'b1;
        run_cleared(40);
        hold = 1'b0;
        // Re-enable only once the synchroniser has seen the pin high
        repeat (4) @(negedge clk);
        ext_en = 1'b1;
        $display("Test pin disabled done");

        // Clock enable low freezes the sequence in the register init step
        low_voltage_detector = 1'b1;
        @(negedge clk);
        low_voltage_detector = 1'b0;
        @(negedge clk);
        clk_en = 1'b0;
        repeat (40) @(negedge clk);
        check("frozen", {1'b0, cpu_run}, 2'h0);
        clk_en = 1'b1;
        wait_run(1'b1, WARM + 10, n);
        check("thaw len", 16'(n), 16'(WARM + 1));
        $display("Test clock enable done");

        // Power-up with the pin held low stays in reset until release
        hold = 1'b1;
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (40) @(negedge clk);
        check("pwrup hold", {sys_rst_n, cpu_run}, 2'h0);
        hold = 1'b0;
        wait_run(1'b1, WARM + 12, n);
        check("pwrup flag", {flag_hi, flag_lo}, cause_of(0, 1));
        $display("Test power-up pin done");
        summarize();
    end
endmodule

`default_nettype wire
